/* rtl/uabr_defines.vh */
// Notes on behaviour
// - Oversample each bit 16 times in normal mode, 8 in double speed.
// - Majority of three centre samples decides data bits and start bit.
// - Votes on samples 8,9,10 normally; 4,5,6 in double speed.
// - Only the first stop bit is checked; further stop bits are ignored.
// - A low voted stop bit flags a frame error for that frame.
// - Next start edge is accepted on the first sample after stop voting.
// - Mode 0x01 selects double speed: same bit time, 8 samples per bit.
// - Generic auto-baud: 12 consecutive low samples are a break; then await sync.
// - Clock counter runs eight bit times from sync start; gives divisor.
// - Generic auto-baud with wait-for-break accepts a break of any length.
// - Generic auto-baud updates divisor only for counts 0x0064..0xffff.
// - LIN auto-baud ignores wait-for-break; break needs 12 clocks low.
// - LIN auto-baud: sync other than 0x55 flags mismatch, keeps the rate.
// - Loop-back feeds the transmit pin into the receiver, drops receive pin.
// - Open drain only pulls low; transmit pin is an output only for low bits.
// - Single-wire mode receives the device's own transmitted frames.
// - RS-485 bit 0 drives the direction pin high while transmitting.
// - Direction rises one bit time before data, holds through the stop.
// - RS-485 bit 1 enables the transmit pin one clock before sending; with bit 0 also set, one bit time before.
// - RS-485 controls and single-wire loop-back may be used together.
// - Start bit accepted when two or three votes are low, else rejected.
// - Mode 0x00 is normal speed, 0x01 double speed.
// - Mode 0x03 is LIN-constrained auto-baud.
`ifndef UABR_DEFINES_VH
`define UABR_DEFINES_VH

// Receive mode encodings
`define UABR_MODE_NORMAL  2'h0
`define UABR_MODE_DOUBLE  2'h1
`define UABR_MODE_GENERIC_AUTOBAUD_MODE 2'h2
`define UABR_MODE_LIN_CONSTRAINED_AUTOBAUD_MODE 2'h3

// Samples per bit and first voting sample
`define UABR_S_NORMAL  5'h10
`define UABR_S_DOUBLE  5'h08
`define UABR_SF_NORMAL 5'h08
`define UABR_SF_DOUBLE 5'h04

// Divisor holds clocks per eight bits; sample period is a shift of it
`define UABR_SH_NORMAL 4'h7
`define UABR_SH_DOUBLE 4'h6
`define UABR_BAUD_RST  16'h0800

// Break and sync measurement
`define UABR_BRK_SAMPLES  5'h0c
`define UABR_BRK_LIN_CLKS 16'h000c
`define UABR_SYNC_FALLS   3'h5
`define UABR_BAUD_MIN     17'h00064
`define UABR_BAUD_MAX     17'h0ffff
`define UABR_MEAS_SAT     17'h1ffff

// Receive buffer shape
`define UABR_FIFO_WIDTH 9
`define UABR_FIFO_DEPTH 16
`define UABR_FIFO_AW    4

`endif

/* rtl/uabr_uart.v */
`timescale 1ns/1ps
`include "uabr_defines.vh"

// Receive buffer with a registered head word
module uabr_fifo #(
  parameter WIDTH = `UABR_FIFO_WIDTH,
  parameter DEPTH = `UABR_FIFO_DEPTH,
  parameter AW    = `UABR_FIFO_AW
) (
  // Clock and control
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire             en_in,
  // Fill side
  input  wire             wr_valid_in,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             wr_ready_out,
  // Drain side
  output reg              rd_valid_out,
  output reg  [WIDTH-1:0] rd_data_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            do_wr;
  wire            do_rd;

  // Head register reloads when empty or when the drain takes it
  assign wr_ready_out = (count_q != DEPTH[AW:0]);
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = (count_q != {(AW+1){1'b0}}) &
                 (~rd_valid_out | rd_ready_in);

  // Storage array has no reset; only written slots are ever read
  always @(posedge clk_in) begin
    if (en_in && do_wr) begin
      mem[wr_ptr_q] <= wr_data_in;
    end
  end

  // Pointers, fill count and head word
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q     <= {AW{1'b0}};
      rd_ptr_q     <= {AW{1'b0}};
      count_q      <= {(AW+1){1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out  <= {WIDTH{1'b0}};
    end else if (en_in) begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_q    <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        rd_data_out <= mem[rd_ptr_q];
      end
      if (do_wr && !do_rd) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule // uabr_fifo

// Asynchronous receiver with auto-baud, small transmitter, half duplex
module uabr_uart (
  // Clock, reset and enable
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       clk_en_in,
  // Configuration
  input  wire [1:0] receive_mode_select_in,
  input  wire       wait_break_enable_in,
  input  wire       loopback_wire_enable_in,
  input  wire       open_drain_enable_in,
  input  wire [1:0] rs485_mode_in,
  // Divisor load and readback
  input  wire        baud_wr_in,
  input  wire [15:0] baud_wdata_in,
  output reg  [15:0] baud_out,
  // Status
  input  wire       sync_mismatch_clr_in,
  output reg        sync_mismatch_flag_out,
  input  wire       overrun_clr_in,
  output reg        rx_overrun_out,
  // Received data stream
  output wire       rx_valid_out,
  output wire [7:0] rx_data_out,
  output wire       rx_frame_err_out,
  input  wire       rx_ready_in,
  // Transmit request
  input  wire       tx_start_in,
  input  wire [7:0] tx_data_in,
  output reg        tx_busy_out,
  // Pins
  input  wire       rxd_in,
  input  wire       txd_in,
  output reg        txd_out,
  output reg        txd_oe_out,
  output reg        driver_direction_out
);
  localparam R_IDLE = 3'h0;
  localparam R_START = 3'h1;
  localparam R_DATA = 3'h2;
  localparam R_STOP = 3'h3;
  localparam R_BRK_END = 3'h4;
  localparam R_SYNC_WAIT = 3'h5;
  localparam R_SYNC_MEAS = 3'h6;
  localparam R_SYNC_TAIL = 3'h7;
  localparam T_IDLE = 2'h0;
  localparam T_GUARD = 2'h1;
  localparam T_SEND = 2'h2;

  // Majority of three votes
  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // One sync interval should be a quarter of the total, within 12.5 percent below and 25 percent above
  function iv_ok;
    input [16:0] iv;
    input [16:0] total;
    reg   [18:0] four;
    reg   [18:0] tot;
    begin
      four  = {iv, 2'b00};
      tot   = {2'b00, total};
      iv_ok = (four + {4'h0, tot[18:4]} >= tot + {2'b00, tot[18:2]} -
               {2'b00, tot[18:2]} - {4'h0, tot[18:4]} - {4'h0, tot[18:4]}
               + {4'h0, tot[18:4]}) &&
              (four <= tot + {2'b00, tot[18:2]});
    end
  endfunction

  reg  [15:0] pre_q;
  reg  [2:0]  rst_q;
  reg  [4:0]  scnt_q;
  reg  [1:0]  vote_q;
  reg  [2:0]  bit_q;
  reg  [7:0]  shreg_q;
  reg         armed_q;
  reg         line_q;
  reg  [15:0] low_clk_q;
  reg  [4:0]  low_smp_q;
  reg  [16:0] meas_q;
  reg  [16:0] last_q;
  reg  [2:0]  falls_q;
  reg  [16:0] iv_q [0:2];
  reg         push_q;
  reg  [8:0]  push_data_q;
  reg  [1:0]  tst_q;
  reg  [4:0]  tcnt_q;
  reg  [3:0]  tbit_q;
  reg  [9:0]  tshift_q;
  wire        line;
  wire        dbl;
  wire        auto_md;
  wire        lin_md;
  wire [4:0]  s_per_bit;
  wire [4:0]  s_first;
  wire [15:0] period;
  wire        tick;
  wire [4:0]  scnt_n;
  wire        brk_hit;
  wire        fall;
  wire [16:0] iv_now;
  wire [3:0]  iv_good;
  wire        in_rng;
  wire        fifo_ready;
  wire        tx_active;
  wire        tx_lvl;

  // Receiver input: own transmit pin in single-wire mode
  assign line = loopback_wire_enable_in ? txd_in : rxd_in;

  // Mode decode
  assign dbl     = (receive_mode_select_in == `UABR_MODE_DOUBLE);
  assign lin_md  = (receive_mode_select_in == `UABR_MODE_LIN_CONSTRAINED_AUTOBAUD_MODE);
  assign auto_md = lin_md |
                   (receive_mode_select_in == `UABR_MODE_GENERIC_AUTOBAUD_MODE);
  assign s_per_bit = dbl ? `UABR_S_DOUBLE : `UABR_S_NORMAL;
  assign s_first   = dbl ? `UABR_SF_DOUBLE : `UABR_SF_NORMAL;
  assign period = (baud_out >> (dbl ? `UABR_SH_DOUBLE : `UABR_SH_NORMAL));
  assign tick   = (pre_q == 16'h0000);
  assign scnt_n = (scnt_q == s_per_bit) ? 5'h01 : scnt_q + 5'h01;
  assign fall   = line_q & ~line;

  // Break: LIN counts clocks, generic counts samples or any low with wait
  assign brk_hit = auto_md && !line && (rst_q <= R_STOP) &&
    (lin_md ? (low_clk_q >= `UABR_BRK_LIN_CLKS - 16'h0001)
            : (wait_break_enable_in ||
               (tick && low_smp_q >= `UABR_BRK_SAMPLES - 5'h01)));

  // Sync intervals between falling edges; a 0x55 gives four equal ones
  assign iv_now = meas_q - last_q;
  assign in_rng = (meas_q >= `UABR_BAUD_MIN) &&
                  (meas_q <= `UABR_BAUD_MAX);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_iv
      if (gi < 3) begin : g_old
        assign iv_good[gi] = iv_ok(iv_q[gi], meas_q);
      end else begin : g_new
        assign iv_good[gi] = iv_ok(iv_now, meas_q);
      end
    end
  endgenerate

  // Sample prescaler; a zero divisor still gives one clock per sample
  always @(posedge clk_in) begin
    if (rst_in) begin
      pre_q <= 16'h0000;
    end else if (clk_en_in) begin
      if (tick || rst_q == R_SYNC_MEAS) begin
        pre_q <= (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
      end else begin
        pre_q <= pre_q - 16'h0001;
      end
    end
  end

  // Low run length for break detection
  always @(posedge clk_in) begin
    if (rst_in) begin
      line_q    <= 1'b1;
      low_clk_q <= 16'h0000;
      low_smp_q <= 5'h00;
    end else if (clk_en_in) begin
      line_q <= line;
      if (line) begin
        low_clk_q <= 16'h0000;
        low_smp_q <= 5'h00;
      end else begin
        if (low_clk_q != 16'hffff) begin
          low_clk_q <= low_clk_q + 16'h0001;
        end
        if (tick && low_smp_q != 5'h1f) begin
          low_smp_q <= low_smp_q + 5'h01;
        end
      end
    end
  end

  // Receive state machine, frame recovery and sync measurement
  always @(posedge clk_in) begin
    if (rst_in) begin
      rst_q       <= R_IDLE;
      scnt_q      <= 5'h00;
      vote_q      <= 2'h3;
      bit_q       <= 3'h0;
      shreg_q     <= 8'h00;
      armed_q     <= 1'b0;
      meas_q      <= 17'h00000;
      last_q      <= 17'h00000;
      falls_q     <= 3'h0;
      iv_q[0]     <= 17'h00000;
      iv_q[1]     <= 17'h00000;
      iv_q[2]     <= 17'h00000;
      push_q      <= 1'b0;
      push_data_q <= 9'h000;
      baud_out    <= `UABR_BAUD_RST;
      sync_mismatch_flag_out <= 1'b0;
      rx_overrun_out         <= 1'b0;
    end else if (clk_en_in) begin
      push_q <= 1'b0;
      // Sticky flags: a new event wins over a clear in the same cycle
      if (sync_mismatch_clr_in) begin
        sync_mismatch_flag_out <= 1'b0;
      end
      if (overrun_clr_in) begin
        rx_overrun_out <= 1'b0;
      end
      if (push_q && !fifo_ready) begin
        rx_overrun_out <= 1'b1;
      end
      if (baud_wr_in) begin
        baud_out <= baud_wdata_in;
      end
      if (brk_hit) begin
        rst_q <= R_BRK_END;
      end else begin
        case (rst_q)
          R_IDLE: begin
            if (tick) begin
              if (line) begin
                armed_q <= 1'b1;
              end else if (armed_q) begin
                armed_q <= 1'b0; // Sample 1 is the first low one
                scnt_q  <= 5'h01;
                rst_q   <= R_START;
              end
            end
          end
          R_START, R_DATA, R_STOP: begin
            if (tick) begin
              scnt_q <= scnt_n;
              if (scnt_n == s_first || scnt_n == s_first + 5'h01) begin
                vote_q <= {vote_q[0], line};
              end
              if (scnt_n == s_first + 5'h02) begin
                case (rst_q)
                  R_START: begin
                    // Two or more low votes accept the start bit
                    if (!maj3(vote_q[1], vote_q[0], line)) begin
                      bit_q <= 3'h0;
                      rst_q <= R_DATA;
                    end else begin
                      rst_q <= R_IDLE;
                    end
                  end
                  R_DATA: begin
                    shreg_q <= {maj3(vote_q[1], vote_q[0], line),
                                shreg_q[7:1]};
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                      rst_q <= R_STOP;
                    end
                  end
                  default: begin
                    // Only the first stop bit counts; low means frame error
                    push_q      <= 1'b1;
                    push_data_q <= {~maj3(vote_q[1], vote_q[0], line),
                                    shreg_q};
                    // Hunt restarts on the very next sample
                    armed_q <= maj3(vote_q[1], vote_q[0], line);
                    rst_q   <= R_IDLE;
                  end
                endcase
              end
            end
          end
          R_BRK_END: begin
            if (line) begin
              rst_q <= R_SYNC_WAIT;
            end
          end
          R_SYNC_WAIT: begin
            if (fall) begin
              meas_q  <= 17'h00001; // Edge cycle is the first count
              last_q  <= 17'h00000;
              falls_q <= 3'h1;
              rst_q   <= R_SYNC_MEAS;
            end
          end
          R_SYNC_MEAS: begin
            if (meas_q == `UABR_MEAS_SAT) begin
              // Far too slow: give up, divisor stays as it was
              if (lin_md) begin
                sync_mismatch_flag_out <= 1'b1;
              end
              rst_q <= R_SYNC_TAIL;
            end else if (fall && falls_q == `UABR_SYNC_FALLS - 3'h1) begin
              // Fifth falling edge marks eight bit times
              if (lin_md && !(in_rng && (&iv_good))) begin
                sync_mismatch_flag_out <= 1'b1;
              end else if (in_rng) begin
                baud_out <= meas_q[15:0];
              end
              rst_q <= R_SYNC_TAIL;
            end else begin
              meas_q <= meas_q + 17'h00001;
              if (fall) begin
                iv_q[falls_q[1:0] - 2'h1] <= iv_now;
                last_q  <= meas_q;
                falls_q <= falls_q + 3'h1;
              end
            end
          end
          R_SYNC_TAIL: begin
            if (line) begin
              armed_q <= 1'b1;
              rst_q   <= R_IDLE;
            end
          end
          default: begin
            rst_q <= R_IDLE;
          end
        endcase
      end
    end
  end

  // Transmitter: guard time for the line driver, then ten bits
  assign tx_active = (tst_q != T_IDLE);
  assign tx_lvl    = (tst_q == T_SEND) ? tshift_q[0] : 1'b1;

  always @(posedge clk_in) begin
    if (rst_in) begin
      tst_q    <= T_IDLE;
      tcnt_q   <= 5'h00;
      tbit_q   <= 4'h0;
      tshift_q <= 10'h3ff;
    end else if (clk_en_in) begin
      case (tst_q)
        T_IDLE: begin
          if (tx_start_in) begin
            tshift_q <= {1'b1, tx_data_in, 1'b0};
            tbit_q   <= 4'h0;
            tcnt_q   <= 5'h00;
            // A bit of guard for direction, one clock for the pin enable
            tst_q <= (rs485_mode_in != 2'h0) ? T_GUARD : T_SEND;
          end
        end
        T_GUARD: begin
          if (!rs485_mode_in[0]) begin
            tst_q <= T_SEND;
          end else if (tick) begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == s_per_bit - 5'h01) begin
              tcnt_q <= 5'h00;
              tst_q  <= T_SEND;
            end
          end
        end
        T_SEND: begin
          if (tick) begin
            tcnt_q <= tcnt_q + 5'h01;
            if (tcnt_q == s_per_bit - 5'h01) begin
              tcnt_q   <= 5'h00;
              tshift_q <= {1'b1, tshift_q[9:1]};
              tbit_q   <= tbit_q + 4'h1;
              if (tbit_q == 4'h9) begin
                tst_q <= T_IDLE;
              end
            end
          end
        end
        default: begin
          tst_q <= T_IDLE;
        end
      endcase
    end
  end

  // Pin outputs, registered together so their relative timing holds
  always @(posedge clk_in) begin
    if (rst_in) begin
      tx_busy_out          <= 1'b0;
      txd_out              <= 1'b1;
      txd_oe_out           <= 1'b0;
      driver_direction_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_busy_out <= tx_active;
      // Open drain never drives high, only enables to pull low
      txd_out <= open_drain_enable_in ? 1'b0 : tx_lvl;
      if (open_drain_enable_in) begin
        txd_oe_out <= ~tx_lvl;
      end else if (rs485_mode_in[1]) begin
        txd_oe_out <= tx_active;
      end else begin
        txd_oe_out <= 1'b1;
      end
      driver_direction_out <= rs485_mode_in[0] & tx_active;
    end
  end

  // Received frames queue here; a full queue loses the frame
  uabr_fifo #(
    .WIDTH (`UABR_FIFO_WIDTH),
    .DEPTH (`UABR_FIFO_DEPTH),
    .AW    (`UABR_FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .en_in        (clk_en_in),
    .wr_valid_in  (push_q),
    .wr_data_in   (push_data_q),
    .wr_ready_out (fifo_ready),
    .rd_valid_out (rx_valid_out),
    .rd_data_out  ({rx_frame_err_out, rx_data_out}),
    .rd_ready_in  (rx_ready_in)
  );
endmodule // uabr_uart

/* bench/uabr_uart_assertions.sv */
`timescale 1ns/1ps
// Port checks for the half-duplex receiver and transmitter
module uabr_uart_assertions (
  // Clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // Configuration
  input wire [1:0]  receive_mode_select_in,
  input wire        open_drain_enable_in,
  input wire [1:0]  rs485_mode_in,
  input wire        baud_wr_in,
  // Watched outputs
  input wire [15:0] baud_out,
  input wire        sync_mismatch_flag_out,
  input wire        tx_busy_out,
  input wire        txd_out,
  input wire        txd_oe_out,
  input wire        driver_direction_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Open drain may pull low only, so a short on the wire is impossible
  a_od_low_only: assert property (
    $past(open_drain_enable_in) && open_drain_enable_in
    |-> !(txd_oe_out && txd_out)) else $error("open drain drove high");
  // Direction leads the start bit by a guard time
  a_dir_guard: assert property (
    $rose(driver_direction_out) && !open_drain_enable_in
    |-> txd_out [*8]) else $error("start bit too soon");
  // Direction only drops after a high stop bit
  a_dir_stop: assert property (
    $fell(driver_direction_out)
    |-> txd_out && $past(txd_out, 8)) else $error("direction cut frame");
  // Every low bit driven out is covered by direction
  a_dir_covers: assert property (
    rs485_mode_in[0] && !open_drain_enable_in && $fell(txd_out)
    |-> driver_direction_out) else $error("low bit without direction");
  // Direction stays low without its control bit
  a_dir_off: assert property (
    !rs485_mode_in[0] && !$past(rs485_mode_in[0])
    |-> !driver_direction_out) else $error("direction without control");
  // Pin turns output one clock ahead of the start bit
  a_oe_early: assert property (
    rs485_mode_in == 2'h2 && !open_drain_enable_in && $rose(txd_oe_out)
    |=> $fell(txd_out)) else $error("output enable not one clock early");
  // Pin returns to input once the frame is over
  a_oe_release: assert property (
    rs485_mode_in == 2'h2 && !open_drain_enable_in && $fell(tx_busy_out)
    |-> ##[0:4] !txd_oe_out) else $error("pin left as output");
  // Sync mismatch flag only rises in LIN auto-baud
  a_flag_lin: assert property (
    $past(receive_mode_select_in) != 2'h3 && !$past(sync_mismatch_flag_out)
    |-> !sync_mismatch_flag_out) else $error("mismatch outside LIN");
  // A mismatch leaves the divisor alone
  a_flag_keep: assert property (
    $rose(sync_mismatch_flag_out) |-> $stable(baud_out))
    else $error("divisor changed on mismatch");
  // Plain modes never change the divisor by themselves
  a_baud_sw: assert property (
    !$past(baud_wr_in) && !$past(rst_in)
    && !$past(receive_mode_select_in[1])
    |-> $stable(baud_out)) else $error("divisor changed in plain mode");
  // Measured divisor is never below the floor
  a_baud_range: assert property (
    $changed(baud_out) && !$past(baud_wr_in) && !$past(rst_in)
    |-> baud_out >= 16'h0064) else $error("divisor below floor");
endmodule // uabr_uart_assertions

bind uabr_uart uabr_uart_assertions u_chk (
  .clk_in                 (clk_in),
  .rst_in                 (rst_in),
  .receive_mode_select_in (receive_mode_select_in),
  .open_drain_enable_in   (open_drain_enable_in),
  .rs485_mode_in          (rs485_mode_in),
  .baud_wr_in             (baud_wr_in),
  .baud_out               (baud_out),
  .sync_mismatch_flag_out (sync_mismatch_flag_out),
  .tx_busy_out            (tx_busy_out),
  .txd_out                (txd_out),
  .txd_oe_out             (txd_oe_out),
  .driver_direction_out   (driver_direction_out)
);

/* bench/uabr_remote_tx.sv */
`timescale 1ns/1ps
// Remote transmitter; its line idles high as through a pull-up
module uabr_remote_tx (
  // Clock
  input wire clk_in,
  // Serial line
  output reg line_out
);
  initial line_out = 1'b1;

  // Hold a level for some clocks; caller enters at a falling edge
  task hold(input logic lvl, input int clks);
    line_out = lvl;
    repeat (clks) @(negedge clk_in);
  endtask

  // Start, eight bits LSB first, stop of chosen level and length
  task send(input logic [7:0] d, input int bt, input logic stp,
            input int sl);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) hold(d[i], bt);
    hold(stp, sl);
    line_out = 1'b1;
  endtask
endmodule // uabr_remote_tx

/* bench/tb_top.sv */
`timescale 1ns/1ps
// Regression for the auto-baud receiver and half-duplex transmitter
module tb_top;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [1:0]  mode = 2'h0;
  reg         wait_break_enable = 1'b0;
  reg         lbk = 1'b0;
  reg         od = 1'b0;
  reg  [1:0]  rs485 = 2'h0;
  reg         bwr = 1'b0;
  reg  [15:0] bwd = 16'h0;
  reg         smclr = 1'b0;
  reg         ovclr = 1'b0;
  reg         rdy = 1'b0;
  reg         txs = 1'b0;
  reg  [7:0]  txdat = 8'h0;
  wire [15:0] baud;
  wire [7:0]  rxb;
  wire        smf, ovr, rxv, ferr, busy, txo, txoe, dir, line, txw;
  int         fail_count = 0;
  int         n_compared = 0;
  int         cyc = 0;

  // Shared wire resolves through a pull-up when nobody drives
  assign txw = txoe ? txo : 1'b1;

  uabr_remote_tx rtx (.clk_in(clk_in), .line_out(line));

  uabr_uart dut (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .receive_mode_select_in(mode), .wait_break_enable_in(wait_break_enable),
    .loopback_wire_enable_in(lbk), .open_drain_enable_in(od),
    .rs485_mode_in(rs485), .baud_wr_in(bwr), .baud_wdata_in(bwd),
    .baud_out(baud), .sync_mismatch_clr_in(smclr),
    .sync_mismatch_flag_out(smf), .overrun_clr_in(ovclr),
    .rx_overrun_out(ovr), .rx_valid_out(rxv), .rx_data_out(rxb),
    .rx_frame_err_out(ferr), .rx_ready_in(rdy), .tx_start_in(txs),
    .tx_data_in(txdat), .tx_busy_out(busy), .rxd_in(line),
    .txd_in(txw), .txd_out(txo), .txd_oe_out(txoe),
    .driver_direction_out(dir));

  // Free-running clock, 4 ns period
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // Verdict and counts, reached from the end or from the timeout
  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Cycle ceiling well above the expected run of some 6k cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  // Value comparison
  task chk(input logic [16:0] g, input logic [16:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Wait for the buffer head, compare it, then take it
  task get(input logic [7:0] d, input logic fe);
    int n;
    n = 0;
    while (rxv !== 1'b1 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    chk({6'h0, rxv, ferr, rxb}, {6'h0, 1'b1, fe, d});
    rdy = 1'b1;
    @(negedge clk_in);
    rdy = 1'b0;
  endtask

  // Drop any words left in the buffer
  task flush;
    rdy = 1'b1;
    repeat (8) @(negedge clk_in);
    rdy = 1'b0;
  endtask

  // Load the divisor
  task setb(input logic [15:0] v);
    bwd = v;
    bwr = 1'b1;
    @(negedge clk_in);
    bwr = 1'b0;
  endtask

  // Send one byte and wait for the transmitter to finish
  task tx(input logic [7:0] d);
    int n;
    n = 0;
    txdat = d;
    txs = 1'b1;
    @(negedge clk_in);
    txs = 1'b0;
    repeat (3) @(negedge clk_in);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  // Break, idle gap, then a sync character at the new bit time
  task autob(input int brk, input logic [7:0] s, input int bt);
    rtx.hold(1'b0, brk);
    rtx.hold(1'b1, 20);
    rtx.send(s, bt, 1'b1, bt);
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk(baud, 16'h0800);
    setb(16'h0080); // Sixteen clocks per bit in both speeds
    rtx.hold(1'b1, 20); // Let the prescaler reach the new sample rate
    rtx.send(8'ha5, 16, 1'b1, 16);
    get(8'ha5, 1'b0);
    rtx.send(8'h0f, 16, 1'b1, 12);
    rtx.send(8'hf0, 16, 1'b1, 16);
    get(8'h0f, 1'b0);
    get(8'hf0, 1'b0);
    rtx.send(8'h33, 16, 1'b0, 16);
    get(8'h33, 1'b1);
    rtx.hold(1'b0, 6); // Glitch too short for the start vote
    rtx.hold(1'b1, 30);
    rtx.send(8'h81, 16, 1'b1, 16);
    get(8'h81, 1'b0);
    $display("test normal done");
    mode = 2'h1;
    rtx.send(8'h3c, 16, 1'b1, 14);
    rtx.send(8'hc3, 16, 1'b1, 16);
    get(8'h3c, 1'b0);
    get(8'hc3, 1'b0);
    $display("test double done");
    mode = 2'h2;
    autob(40, 8'h55, 24);
    chk(baud, 16'h00c0);
    autob(40, 8'h55, 10);
    chk(baud, 16'h00c0);
    wait_break_enable = 1'b1;
    autob(4, 8'h55, 13);
    chk(baud, 16'h0068);
    $display("test generic done");
    mode = 2'h3;
    // Short bits, so no later low run can pass for a break either
    autob(8, 8'h55, 11);
    chk({smf, baud}, {1'b0, 16'h0068});
    wait_break_enable = 1'b0;
    autob(30, 8'h55, 14);
    chk(baud, 16'h0070);
    chk(smf, 1'b0);
    autob(30, 8'hd5, 14);
    rtx.send(8'hff, 14, 1'b1, 14);
    chk({smf, baud}, {1'b1, 16'h0070});
    smclr = 1'b1;
    @(negedge clk_in);
    smclr = 1'b0;
    @(negedge clk_in);
    chk(smf, 1'b0);
    $display("test lin done");
    mode = 2'h0;
    setb(16'h0080);
    flush();
    lbk = 1'b1;
    rs485 = 2'h1;
    rtx.hold(1'b0, 0); // Receive pin held low while disconnected
    tx(8'h96);
    get(8'h96, 1'b0);
    chk(dir, 1'b0);
    rs485 = 2'h0;
    od = 1'b1;
    tx(8'h5a);
    get(8'h5a, 1'b0);
    od = 1'b0;
    rs485 = 2'h2;
    tx(8'hc3);
    get(8'hc3, 1'b0);
    chk(txoe, 1'b0);
    rtx.hold(1'b1, 0);
    lbk = 1'b0;
    rs485 = 2'h0;
    $display("test half duplex done");
    for (int i = 0; i < 18; i++) rtx.send(8'h10 + i, 16, 1'b1, 16);
    chk(ovr, 1'b1);
    for (int i = 0; i < 16; i++) get(8'h10 + i, 1'b0);
    flush();
    ovclr = 1'b1;
    @(negedge clk_in);
    ovclr = 1'b0;
    @(negedge clk_in);
    chk(ovr, 1'b0);
    $display("test buffer done");
    stop_test();
  end
endmodule // tb_top
